// ---- psmc_map.vh ----
// Register offsets, field positions, reset values and timing counts of the power-save controller.
`ifndef PSMC_MAP_VH
`define PSMC_MAP_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define PSMC_CTRL_OFS 4'h0
`define PSMC_STAT_OFS 4'h4
`define PSMC_CLKS_OFS 4'h8

// ----------------------------------------------------------------------------
// Control register fields and reset value
// ----------------------------------------------------------------------------
`define PSMC_CTRL_OSC_MAN_EN 0
`define PSMC_CTRL_RET_EN 1
`define PSMC_CTRL_WDT_EN 2
`define PSMC_CTRL_FAIL_SAFE_CLOCK_MONITOR_EN 3
`define PSMC_CTRL_W 4
`define PSMC_CTRL_RST 4'h0

// ----------------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------------
`define PSMC_STAT_RUN 0
`define PSMC_STAT_IDLE 1
`define PSMC_STAT_SLEEP 2
`define PSMC_STAT_DEEP 3
`define PSMC_STAT_OSC_ON 4
`define PSMC_STAT_OSC_RDY 5
`define PSMC_STAT_DS_FAIL 6
`define PSMC_STAT_RET_ON 7

// ----------------------------------------------------------------------------
// Power-save operands and timing
// ----------------------------------------------------------------------------
`define PSMC_OP_SLEEP 1'b0
`define PSMC_OP_IDLE 1'b1
`define PSMC_UNLOCK_INSNS 3'h5
`define PSMC_CLK_PERIOD_NS 50
`define PSMC_OSC_START_MS 1000
`define PSMC_OSC_START_CYC ((`PSMC_OSC_START_MS * 1000000) / `PSMC_CLK_PERIOD_NS)

// ----------------------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------------------
`define PSMC_RESP_OKAY 2'h0
`define PSMC_RESP_SLVERR 2'h2

`endif

// ---- psmc_osc_timer.v ----
// Start-up timer that reports when the secondary oscillator has settled.
`include "psmc_map.vh"

module psmc_osc_timer #(
  parameter CNT_W = 25,
  parameter [24:0] START_CYC = 25'h1312D00
) (
  // Clock and reset
  input wire ref_clk_i,
  input wire srst_i,
  // Oscillator run request and settled flag
  input wire run_i,
  output wire ready_o
);

  reg [CNT_W-1:0] cnt_ff;
  reg rdy_ff;
  wire [CNT_W-1:0] nxt_cnt;
  wire nxt_rdy;

  // Any stop of the oscillator restarts the settling count.
  assign nxt_cnt = !run_i ? {CNT_W{1'b0}} : (rdy_ff ? cnt_ff : cnt_ff + 1'b1);
  assign nxt_rdy = run_i && (rdy_ff || (cnt_ff + 1'b1 >= START_CYC));

  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      cnt_ff <= {CNT_W{1'b0}};
      rdy_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      rdy_ff <= nxt_rdy;
    end
  end

  assign ready_o = rdy_ff;

endmodule

// ---- psmc_power_save_ctrl.v ----
// Power-save mode controller: Sleep, Idle and Deep Sleep sequencing with register access.
//
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`include "psmc_map.vh"

// What this block does
// - Dependent module request starts secondary oscillator.
// - Manual enable pre-starts slow-settling oscillator.
// - Select fuse zero makes oscillator pins digital.
// - Sleep instruction stops clocks and execution.
// - Idle halts core, peripherals keep running.
// - Deep Sleep stops all but calendar, watchdog.
// - Interrupt in five-instruction unlock aborts Deep Sleep.
// - Enabled interrupt, watchdog, reset wake Sleep/Idle.
// - Coincident interrupt deferred, then immediate wake.
// - Deep Sleep interrupt lost unless regulator on.
// - Retention regulator active only in Sleep/Deep.
// - Regulator needs fuse zero and firmware bit.
// - Entering Idle clears the watchdog count.
// - Idle keeps system clock for peripherals.
// - Idle keeps RC oscillator for watchdog/monitor.
// - Idle wake resumes next instruction or handler.
// - Watchdog cleared in the first cycle of Sleep.
// - Sleep wake restores the entry clock source.
module psmc_power_save_ctrl #(
  parameter [24:0] OSC_START_CYC = `PSMC_OSC_START_CYC
) (
  // Clock and reset
  input wire ref_clk_i,
  input wire srst_i,
  // AXI4-Lite write address and data
  input wire [3:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output wire s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output wire s_axi_wready_o,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp_o,
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  // AXI4-Lite read
  input wire [3:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output wire s_axi_arready_o,
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i,
  // Core instruction stream
  input wire core_insn_strobe_i,
  input wire power_save_instruction_i,
  input wire power_save_operand_i,
  input wire deep_sleep_arm_bit_wr_i,
  input wire [2:0] core_clk_src_i,
  // Wake sources
  input wire irq_pending_i,
  input wire wdt_timeout_i,
  input wire deep_wake_i,
  // Configuration fuses
  input wire secondary_osc_pin_select_i,
  input wire low_power_config_fuse_i,
  // Oscillator requests from dependent modules
  input wire osc_module_req_i,
  // Power and clock controls
  output reg core_halt_o,
  output reg sys_clk_stop_o,
  output reg periph_stop_o,
  output reg io_freeze_o,
  output reg flash_pwr_off_o,
  output reg sram_pwr_off_o,
  output reg retention_regulator_on_o,
  output reg low_power_rc_oscillator_run_o,
  output reg secondary_low_freq_oscillator_run_o,
  output wire secondary_osc_ready_o,
  output reg secondary_osc_pins_digital_o,
  output reg wdt_clear_o,
  output reg [2:0] core_clk_src_o,
  // Wake results toward the core
  output reg resume_o,
  output reg resume_isr_o,
  output reg deep_exit_reset_o
);

  // --------------------------------------------------------------------------
  // Mode states
  // --------------------------------------------------------------------------
  localparam [3:0] ST_RUN = 4'h1;
  localparam [3:0] ST_IDLE = 4'h2;
  localparam [3:0] ST_SLEEP = 4'h4;
  localparam [3:0] ST_DEEP = 4'h8;

  reg [3:0] state_ff;
  reg [3:0] nxt_state;
  reg [`PSMC_CTRL_W-1:0] ctrl_ff;
  reg [2:0] saved_clk_ff;
  reg [2:0] unlock_cnt_ff;
  reg [2:0] nxt_unlock_cnt;
  reg [1:0] arm_cnt_ff;
  reg [1:0] nxt_arm_cnt;
  reg ds_fail_ff;
  reg nxt_ds_fail;
  reg enter_idle;
  reg enter_sleep;
  reg enter_deep;
  reg wake;

  wire osc_man_en;
  wire ret_en;
  wire wdt_en;
  wire fail_safe_clock_monitor_en;
  wire ret_allowed;
  wire osc_run;
  wire wr_go;
  wire rd_go;

  assign osc_man_en = ctrl_ff[`PSMC_CTRL_OSC_MAN_EN];
  assign ret_en = ctrl_ff[`PSMC_CTRL_RET_EN];
  assign wdt_en = ctrl_ff[`PSMC_CTRL_WDT_EN];
  assign fail_safe_clock_monitor_en = ctrl_ff[`PSMC_CTRL_FAIL_SAFE_CLOCK_MONITOR_EN];
  assign ret_allowed = !low_power_config_fuse_i && ret_en;

  // --------------------------------------------------------------------------
  // Deep Sleep unlock tracking
  // --------------------------------------------------------------------------
  // The arm count only survives while the unlock window is open and no
  // interrupt has arrived; anything else disarms, and all but a power-save
  // instruction or leaving Run also records a failure.
  always @* begin
    nxt_arm_cnt = arm_cnt_ff;
    nxt_unlock_cnt = unlock_cnt_ff;
    nxt_ds_fail = ds_fail_ff;
    if (state_ff != ST_RUN) begin
      nxt_arm_cnt = 2'h0;
      nxt_unlock_cnt = 3'h0;
    end else if (arm_cnt_ff != 2'h0 && irq_pending_i) begin
      nxt_arm_cnt = 2'h0;
      nxt_unlock_cnt = 3'h0;
      nxt_ds_fail = 1'b1;
    end else if (core_insn_strobe_i) begin
      if (deep_sleep_arm_bit_wr_i) begin
        if (arm_cnt_ff == 2'h0) begin
          nxt_arm_cnt = 2'h1;
          nxt_unlock_cnt = 3'h1;
          nxt_ds_fail = 1'b0;
        end else if (arm_cnt_ff == 2'h1 && unlock_cnt_ff == 3'h1) begin
          nxt_arm_cnt = 2'h2;
          nxt_unlock_cnt = 3'h2;
        end else begin
          nxt_arm_cnt = 2'h0;
          nxt_unlock_cnt = 3'h0;
          nxt_ds_fail = 1'b1;
        end
      end else if (arm_cnt_ff != 2'h0) begin
        if (power_save_instruction_i) begin
          nxt_arm_cnt = 2'h0;
          nxt_unlock_cnt = 3'h0;
        end else if (unlock_cnt_ff + 3'h1 >= `PSMC_UNLOCK_INSNS) begin
          nxt_arm_cnt = 2'h0;
          nxt_unlock_cnt = 3'h0;
          nxt_ds_fail = 1'b1;
        end else begin
          nxt_unlock_cnt = unlock_cnt_ff + 3'h1;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Mode state machine
  // --------------------------------------------------------------------------
  always @* begin
    nxt_state = state_ff;
    enter_idle = 1'b0;
    enter_sleep = 1'b0;
    enter_deep = 1'b0;
    wake = 1'b0;
    case (state_ff)
      ST_RUN: begin
        // A coincident interrupt does not block entry; it wakes next cycle.
        if (core_insn_strobe_i && power_save_instruction_i) begin
          if (power_save_operand_i == `PSMC_OP_IDLE) begin
            nxt_state = ST_IDLE;
            enter_idle = 1'b1;
          end else if (arm_cnt_ff == 2'h2 && !irq_pending_i) begin
            nxt_state = ST_DEEP;
            enter_deep = 1'b1;
          end else begin
            nxt_state = ST_SLEEP;
            enter_sleep = 1'b1;
          end
        end
      end
      ST_IDLE, ST_SLEEP: begin
        if (irq_pending_i || wdt_timeout_i) begin
          nxt_state = ST_RUN;
          wake = 1'b1;
        end
      end
      ST_DEEP: begin
        if (deep_wake_i || irq_pending_i) begin
          nxt_state = ST_RUN;
          wake = 1'b1;
        end
      end
      default: begin
        nxt_state = ST_RUN;
      end
    endcase
  end

  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      state_ff <= ST_RUN;
      arm_cnt_ff <= 2'h0;
      unlock_cnt_ff <= 3'h0;
      ds_fail_ff <= 1'b0;
      saved_clk_ff <= 3'h0;
    end else begin
      state_ff <= nxt_state;
      arm_cnt_ff <= nxt_arm_cnt;
      unlock_cnt_ff <= nxt_unlock_cnt;
      ds_fail_ff <= nxt_ds_fail;
      if (enter_sleep || enter_deep) begin
        saved_clk_ff <= core_clk_src_i;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Power, clock and wake outputs
  // --------------------------------------------------------------------------
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      core_halt_o <= 1'b0;
      sys_clk_stop_o <= 1'b0;
      periph_stop_o <= 1'b0;
      io_freeze_o <= 1'b0;
      flash_pwr_off_o <= 1'b0;
      sram_pwr_off_o <= 1'b0;
      retention_regulator_on_o <= 1'b0;
      low_power_rc_oscillator_run_o <= 1'b0;
      wdt_clear_o <= 1'b0;
      core_clk_src_o <= 3'h0;
      resume_o <= 1'b0;
      resume_isr_o <= 1'b0;
      deep_exit_reset_o <= 1'b0;
    end else begin
      core_halt_o <= nxt_state != ST_RUN;
      // Idle leaves the system clock running for the peripherals.
      sys_clk_stop_o <= nxt_state == ST_SLEEP || nxt_state == ST_DEEP;
      periph_stop_o <= nxt_state == ST_DEEP;
      io_freeze_o <= nxt_state == ST_SLEEP || nxt_state == ST_DEEP;
      flash_pwr_off_o <= nxt_state == ST_DEEP;
      sram_pwr_off_o <= nxt_state == ST_DEEP && !ret_allowed;
      retention_regulator_on_o <= ret_allowed &&
        (nxt_state == ST_SLEEP || nxt_state == ST_DEEP);
      low_power_rc_oscillator_run_o <= wdt_en ||
        (nxt_state != ST_SLEEP && nxt_state != ST_DEEP && fail_safe_clock_monitor_en);
      wdt_clear_o <= wdt_en && (enter_idle || enter_sleep);
      if (wake && state_ff == ST_SLEEP) begin
        core_clk_src_o <= saved_clk_ff;
      end else if (nxt_state == ST_RUN) begin
        core_clk_src_o <= core_clk_src_i;
      end
      // Without retention a Deep Sleep exit restarts the core through reset and the interrupt is gone.
      resume_o <= wake && !(state_ff == ST_DEEP && !ret_allowed);
      resume_isr_o <= wake && irq_pending_i &&
        !(state_ff == ST_DEEP && !ret_allowed);
      deep_exit_reset_o <= wake && state_ff == ST_DEEP && !ret_allowed;
    end
  end

  // --------------------------------------------------------------------------
  // Secondary oscillator
  // --------------------------------------------------------------------------
  assign osc_run = secondary_osc_pin_select_i &&
    (osc_module_req_i || osc_man_en);

  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      secondary_low_freq_oscillator_run_o <= 1'b0;
      secondary_osc_pins_digital_o <= 1'b0;
    end else begin
      secondary_low_freq_oscillator_run_o <= osc_run;
      secondary_osc_pins_digital_o <= !secondary_osc_pin_select_i;
    end
  end

  // The settling count tracks the registered run level.
  psmc_osc_timer #(
    .CNT_W(25),
    .START_CYC(OSC_START_CYC)
  ) u_osc_timer (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .run_i(secondary_low_freq_oscillator_run_o),
    .ready_o(secondary_osc_ready_o)
  );

  // --------------------------------------------------------------------------
  // AXI4-Lite register slave
  // --------------------------------------------------------------------------
  assign wr_go = s_axi_awvalid_i && s_axi_wvalid_i && !s_axi_bvalid_o;
  assign s_axi_awready_o = wr_go;
  assign s_axi_wready_o = wr_go;
  assign rd_go = s_axi_arvalid_i && !s_axi_rvalid_o;
  assign s_axi_arready_o = rd_go;

  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      ctrl_ff <= `PSMC_CTRL_RST;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `PSMC_RESP_OKAY;
    end else begin
      if (wr_go) begin
        s_axi_bvalid_o <= 1'b1;
        if (s_axi_awaddr_i == `PSMC_CTRL_OFS) begin
          s_axi_bresp_o <= `PSMC_RESP_OKAY;
          if (s_axi_wstrb_i[0]) begin
            ctrl_ff <= s_axi_wdata_i[`PSMC_CTRL_W-1:0];
          end
        end else if (s_axi_awaddr_i == `PSMC_STAT_OFS ||
                     s_axi_awaddr_i == `PSMC_CLKS_OFS) begin
          s_axi_bresp_o <= `PSMC_RESP_OKAY;
        end else begin
          s_axi_bresp_o <= `PSMC_RESP_SLVERR;
        end
      end else if (s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0;
      s_axi_rresp_o <= `PSMC_RESP_OKAY;
    end else begin
      if (rd_go) begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rresp_o <= `PSMC_RESP_OKAY;
        s_axi_rdata_o <= 32'h0;
        case (s_axi_araddr_i)
          `PSMC_CTRL_OFS: begin
            s_axi_rdata_o <= {28'h0, ctrl_ff};
          end
          `PSMC_STAT_OFS: begin
            s_axi_rdata_o <= {24'h0, retention_regulator_on_o, ds_fail_ff,
              secondary_osc_ready_o, secondary_low_freq_oscillator_run_o, state_ff};
          end
          `PSMC_CLKS_OFS: begin
            s_axi_rdata_o <= {29'h0, saved_clk_ff};
          end
          default: begin
            s_axi_rresp_o <= `PSMC_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end

endmodule

// ---- psmc_checker.sv ----
// Concurrent assertions on the ports of the power-save mode controller.
module psmc_checker #(
  parameter [24:0] OSC_START_CYC = 25'h10
) (
  input wire ref_clk_i, srst_i, core_insn_strobe_i, power_save_instruction_i,
  input wire power_save_operand_i, irq_pending_i, wdt_timeout_i, osc_module_req_i,
  input wire secondary_osc_pin_select_i, low_power_config_fuse_i, core_halt_o,
  input wire sys_clk_stop_o, periph_stop_o, io_freeze_o, retention_regulator_on_o,
  input wire secondary_low_freq_oscillator_run_o, secondary_osc_ready_o,
  input wire secondary_osc_pins_digital_o, wdt_clear_o, resume_o, resume_isr_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [24:0] run_cnt_ff;
  wire ps_req = core_insn_strobe_i && power_save_instruction_i && !core_halt_o;

  // Counts the cycles the oscillator has been running, to bound the settled flag.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || !secondary_low_freq_oscillator_run_o) begin
      run_cnt_ff <= 25'h0;
    end else begin
      run_cnt_ff <= run_cnt_ff + 25'h1;
    end
  end

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  sequence idle_enter_s;
    ps_req && power_save_operand_i ##1 core_halt_o;
  endsequence

  idle_entry_a: assert property (ps_req && power_save_operand_i |=>
    core_halt_o && !periph_stop_o && !sys_clk_stop_o) else $error("Idle entry wrong.");
  sleep_entry_a: assert property (ps_req && !power_save_operand_i |=>
    core_halt_o && sys_clk_stop_o && io_freeze_o) else $error("Sleep entry wrong.");
  wdt_clear_a: assert property (wdt_clear_o |-> $past(ps_req))
    else $error("Watchdog clear outside entry.");
  deferred_wake_a: assert property (idle_enter_s ##0 irq_pending_i |=>
    resume_o && resume_isr_o && !core_halt_o) else $error("Deferred wake missing.");
  wdt_wake_a: assert property (core_halt_o && !periph_stop_o && wdt_timeout_i |=>
    !core_halt_o) else $error("Watchdog wake missing.");
  regulator_gate_a: assert property (retention_regulator_on_o |->
    sys_clk_stop_o && !low_power_config_fuse_i) else $error("Regulator on wrongly.");
  osc_request_a: assert property (osc_module_req_i && secondary_osc_pin_select_i |=>
    secondary_low_freq_oscillator_run_o) else $error("Oscillator not started.");
  pins_digital_a: assert property (!secondary_osc_pin_select_i |=>
    secondary_osc_pins_digital_o && !secondary_low_freq_oscillator_run_o)
    else $error("Oscillator pins not digital.");
  osc_settle_a: assert property (secondary_osc_ready_o |->
    run_cnt_ff >= OSC_START_CYC - 25'h1) else $error("Oscillator ready too early.");
endmodule

bind psmc_power_save_ctrl psmc_checker #(.OSC_START_CYC(OSC_START_CYC)) u_chk (
  .ref_clk_i, .srst_i, .core_insn_strobe_i, .power_save_instruction_i,
  .power_save_operand_i, .irq_pending_i, .wdt_timeout_i, .osc_module_req_i,
  .secondary_osc_pin_select_i, .low_power_config_fuse_i, .core_halt_o,
  .sys_clk_stop_o, .periph_stop_o, .io_freeze_o, .retention_regulator_on_o,
  .secondary_low_freq_oscillator_run_o, .secondary_osc_ready_o,
  .secondary_osc_pins_digital_o, .wdt_clear_o, .resume_o, .resume_isr_o
);

// ---- psmc_core_model.sv ----
// Behavioural processor core that issues instructions to the power-save controller.
module psmc_core_model (
  input wire ref_clk_i,
  output logic insn_strobe_o, psi_o, operand_o, arm_wr_o, irq_o,
  output logic [2:0] clk_src_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    {insn_strobe_o, psi_o, operand_o, arm_wr_o, irq_o} = 5'h0;
    clk_src_o = 3'h0;
  end

  // One instruction cycle per call; every signal changes just after the edge.
  task automatic step(input logic stb, psi, op, arm, irq);
    @(posedge ref_clk_i);
    insn_strobe_o <= stb;
    psi_o <= psi;
    operand_o <= op;
    arm_wr_o <= arm;
    irq_o <= irq;
  endtask

  // Two arm writes back to back, then the sleep operand; brk lets an interrupt through.
  task automatic deep(input logic brk);
    step(1'h1, 1'h0, 1'h0, 1'h1, 1'h0);
    step(1'h1, 1'h0, 1'h0, 1'h1, brk);
    step(1'h1, 1'h1, 1'h0, 1'h0, 1'h0);
    step(1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
  endtask
endmodule

// ---- psmc_power_save_ctrl_tb.sv ----
// Self-checking testbench for the power-save mode controller.
`include "psmc_map.vh"
module psmc_power_save_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk_i = 1'h0;
  logic srst_i = 1'h1;
  logic [3:0] s_axi_awaddr_i = 4'h0, s_axi_araddr_i = 4'h0, s_axi_wstrb_i = 4'hF;
  logic s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_bready_i = 1'h0;
  logic s_axi_arvalid_i = 1'h0, s_axi_rready_i = 1'h0;
  logic [31:0] s_axi_wdata_i = 32'h0, rdv;
  logic [1:0] rsp;
  logic wdt_timeout_i = 1'h0, deep_wake_i = 1'h0, osc_module_req_i = 1'h0;
  logic secondary_osc_pin_select_i = 1'h1, low_power_config_fuse_i = 1'h0;
  wire core_insn_strobe_i, power_save_instruction_i, power_save_operand_i;
  wire deep_sleep_arm_bit_wr_i, irq_pending_i;
  wire [2:0] core_clk_src_i, core_clk_src_o;
  wire s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  wire [1:0] s_axi_bresp_o, s_axi_rresp_o;
  wire [31:0] s_axi_rdata_o;
  wire core_halt_o, sys_clk_stop_o, periph_stop_o, io_freeze_o, flash_pwr_off_o;
  wire sram_pwr_off_o, retention_regulator_on_o, low_power_rc_oscillator_run_o;
  wire secondary_low_freq_oscillator_run_o, secondary_osc_ready_o;
  wire secondary_osc_pins_digital_o, wdt_clear_o, resume_o, resume_isr_o, deep_exit_reset_o;
  int err_total = 0, checks = 0, cyc = 0;

  psmc_power_save_ctrl #(.OSC_START_CYC(25'h10)) DUT (.*);
  psmc_core_model core (.ref_clk_i, .insn_strobe_o(core_insn_strobe_i),
    .psi_o(power_save_instruction_i), .operand_o(power_save_operand_i),
    .arm_wr_o(deep_sleep_arm_bit_wr_i), .irq_o(irq_pending_i), .clk_src_o(core_clk_src_i));

  always #25 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t ns: saw %h, want %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    if (err_total == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'h1;
    s_axi_wvalid_i <= 1'h1;
    s_axi_bready_i <= 1'h1;
    do @(posedge ref_clk_i); while (!(s_axi_awready_o && s_axi_wready_o));
    s_axi_awvalid_i <= 1'h0;
    s_axi_wvalid_i <= 1'h0;
    do @(posedge ref_clk_i); while (!s_axi_bvalid_o);
    rsp = s_axi_bresp_o;
    s_axi_bready_i <= 1'h0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'h1;
    s_axi_rready_i <= 1'h1;
    do @(posedge ref_clk_i); while (!s_axi_arready_o);
    s_axi_arvalid_i <= 1'h0;
    do @(posedge ref_clk_i); while (!s_axi_rvalid_o);
    rdv = s_axi_rdata_o;
    rsp = s_axi_rresp_o;
    s_axi_rready_i <= 1'h0;
  endtask

  task automatic wake_wdt();
    @(posedge ref_clk_i);
    wdt_timeout_i <= 1'h1;
    core.clk_src_o <= 3'h2;
    @(posedge ref_clk_i);
    wdt_timeout_i <= 1'h0;
    #1;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_regs();
    rd(`PSMC_CTRL_OFS);
    chk(rdv, 32'h0);
    wr(`PSMC_STAT_OFS, 32'hFF);
    chk(rsp, `PSMC_RESP_OKAY);
    rd(`PSMC_STAT_OFS);
    chk(rdv, 32'h1);
    wr(`PSMC_CTRL_OFS, 32'hF);
    rd(`PSMC_CTRL_OFS);
    chk(rdv, 32'hF);
    rd(4'hC);
    chk(rsp, `PSMC_RESP_SLVERR);
    chk(rdv, 32'h0);
  endtask

  task automatic t_idle();
    for (int i = 0; i < 2; i++) begin
      wr(`PSMC_CTRL_OFS, i ? 32'hA : 32'h6);
      core.step(1'h1, 1'h1, 1'h1, 1'h0, 1'h1);
      core.step(1'h0, 1'h0, 1'h0, 1'h0, 1'h1);
      #1;
      chk({core_halt_o, periph_stop_o}, 2'h2);
      chk(sys_clk_stop_o, 1'h0);
      chk(wdt_clear_o, i == 0);
      chk(low_power_rc_oscillator_run_o, 1'h1);
      chk(retention_regulator_on_o, 1'h0);
      core.step(1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
      #1;
      chk({resume_o, resume_isr_o, core_halt_o}, 3'h6);
    end
  endtask

  task automatic t_sleep();
    for (int k = 0; k < 2; k++) begin
      wr(`PSMC_CTRL_OFS, 32'h6);
      low_power_config_fuse_i <= k[0];
      core.clk_src_o <= 3'h5;
      core.step(1'h1, 1'h1, 1'h0, 1'h0, 1'h0);
      core.step(1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
      #1;
      chk({core_halt_o, sys_clk_stop_o, io_freeze_o}, 3'h7);
      chk(wdt_clear_o, 1'h1);
      chk(retention_regulator_on_o, !k[0]);
      wake_wdt();
      chk(core_halt_o, 1'h0);
      chk(core_clk_src_o, 3'h5);
    end
    @(posedge ref_clk_i);
    low_power_config_fuse_i <= 1'h0;
  endtask

  task automatic t_deep();
    for (int r = 0; r < 2; r++) begin
      wr(`PSMC_CTRL_OFS, r ? 32'h2 : 32'h0);
      core.deep(1'h0);
      #1;
      chk({io_freeze_o, flash_pwr_off_o, periph_stop_o, sys_clk_stop_o}, 4'hF);
      chk(sram_pwr_off_o, !r[0]);
      chk(retention_regulator_on_o, r[0]);
      @(posedge ref_clk_i);
      if (r) begin
        core.irq_o <= 1'h1;
      end else begin
        deep_wake_i <= 1'h1;
      end
      @(posedge ref_clk_i);
      core.irq_o <= 1'h0;
      deep_wake_i <= 1'h0;
      #1;
      chk({resume_o, resume_isr_o, deep_exit_reset_o}, r ? 3'h6 : 3'h1);
    end
    core.deep(1'h1);
    #1;
    chk({sys_clk_stop_o, periph_stop_o, flash_pwr_off_o}, 3'h4);
    wake_wdt();
    rd(`PSMC_STAT_OFS);
    chk(rdv[`PSMC_STAT_DS_FAIL], 1'h1);
  endtask

  task automatic t_osc();
    wr(`PSMC_CTRL_OFS, 32'h0);
    osc_module_req_i <= 1'h1;
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk({secondary_low_freq_oscillator_run_o, secondary_osc_ready_o}, 2'h2);
    repeat (20) @(posedge ref_clk_i);
    osc_module_req_i <= 1'h0;
    #1;
    chk(secondary_osc_ready_o, 1'h1);
    wr(`PSMC_CTRL_OFS, 32'h1);
    @(posedge ref_clk_i);
    secondary_osc_pin_select_i <= 1'h0;
    #1;
    chk(secondary_low_freq_oscillator_run_o, 1'h1);
    repeat (2) @(posedge ref_clk_i);
    secondary_osc_pin_select_i <= 1'h1;
    #1;
    chk({secondary_low_freq_oscillator_run_o, secondary_osc_pins_digital_o}, 2'h1);
  endtask

  initial begin
    repeat (10) @(posedge ref_clk_i);
    srst_i <= 1'h0;
    t_regs();
    t_idle();
    t_sleep();
    t_deep();
    t_osc();
    end_sim();
  end
endmodule
